/* File: logic/rpam_pkg.sv */
// Constants, types and register map of the room preset activation manager
//
// Notes on behaviour
// RULE1: A preset's stored parameter word goes out to the mixer only when that preset runs.
// RULE2: Running or changing one preset never touches another preset's mask, parameters or state.
// RULE3: There are six presets, numbered 1 to 6, each with its own mask and parameter register.
// RULE4: The latching contact inputs enable and disable presets with no software involved.
// RULE5: Each preset stores, per contact input, the level (high or low) that input must show.
// RULE6: A contact input marked unused in a preset's mask has no say in that preset's enable.
// RULE7: Presets can also be run by commands written to the command register.
// RULE8: A command is token, keyword, preset number and argument, parsed in that order.
// RULE9: Argument 0 turns the preset's state off without loading it.
// RULE10: Argument 1 loads the preset and turns its state on.
// RULE11: Argument 2 loads the preset and leaves its state off.
// RULE12: Argument 1 to a preset that is already on does not load it again.
// RULE13: Argument 1 to a preset that is off loads it first and only then marks it on.
// RULE14: Each contact input is latched, and a status output shows its latched level.
// RULE15: A preset is enabled only when every used contact input equals its stored level.
// RULE16: A preset number outside 1 to 6 or an argument above 2 is ignored with no effect at all.
`default_nettype none

package rpam_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_PRESETS = 6;
    localparam int NUM_INPUTS  = 7;

    typedef logic [2:0] rpam_idx_t;

    // ----------------------------------------------------------------
    // Register map (word index = haddr[7:2])
    // ----------------------------------------------------------------
    localparam logic [5:0]  IDX_CMD        = 6'h00;
    localparam logic [5:0]  IDX_STATUS     = 6'h01;
    localparam logic [5:0]  IDX_INPUTS     = 6'h02;
    localparam logic [5:0]  IDX_MASK0      = 6'h04;
    localparam logic [5:0]  IDX_MASK_END   = 6'h0a;
    localparam logic [5:0]  IDX_PARAM0     = 6'h0c;
    localparam logic [5:0]  IDX_PARAM_END  = 6'h12;
    localparam logic [23:0] ADDR_HIGH_ZERO = 24'h000000;
    localparam int          MASK_LVL_LSB   = 0;
    localparam int          MASK_USE_LSB   = 8;
    localparam int          STAT_STATE_LSB = 0;
    localparam int          STAT_EN_LSB    = 8;
    localparam int          STAT_PEND_LSB  = 16;
    localparam logic [31:0] PARAM_RST      = 32'h00000000;

    // ----------------------------------------------------------------
    // Command tokens
    // ----------------------------------------------------------------
    localparam logic [7:0] TOK_EXEC    = 8'h40;
    localparam logic [7:0] TOK_PRESET  = 8'h50;
    localparam logic [7:0] PRESET_MIN  = 8'h01;
    localparam logic [7:0] PRESET_MAX  = 8'h06;
    localparam logic [7:0] ARG_MAX     = 8'h02;
    localparam logic [1:0] ARG_OFF     = 2'h0;
    localparam logic [1:0] ARG_RUN_ON  = 2'h1;
    localparam logic [1:0] ARG_RUN_OFF = 2'h2;

    // ----------------------------------------------------------------
    // Bus constants
    // ----------------------------------------------------------------
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic       HRESP_OKAY = 1'b0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {PS_TOKEN, PS_KEY, PS_NUM, PS_ARG} rpam_parse_e;

    typedef enum logic [2:0] {K_NONE, K_CMD, K_STATUS, K_INPUTS, K_MASK, K_PARAM} rpam_kind_e;

    typedef struct packed {
        rpam_kind_e kind;
        rpam_idx_t  idx;
    } rpam_dec_s;

    typedef struct packed {
        logic [NUM_INPUTS-1:0] used;
        logic [NUM_INPUTS-1:0] level;
    } rpam_mask_s;

    typedef struct packed {
        logic       valid;
        rpam_idx_t  num;
        logic [1:0] arg;
    } rpam_cmd_s;

    typedef struct packed {
        logic        wr;
        logic [31:0] addr;
    } rpam_aph_s;

    localparam rpam_mask_s MASK_RST = '0;

endpackage

`default_nettype wire

/* File: logic/rpam_top.sv */
// Room preset activation manager: AHB-Lite registers, contact masks, command parser
`default_nettype none

module rpam_top import rpam_pkg::*; (
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    // AHB-Lite slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output var  logic                  hreadyout,
    output var  logic                  hresp,
    output var  logic [31:0]           hrdata,
    // Partition contact inputs and their status
    input  wire logic [NUM_INPUTS-1:0] select_in,
    output var  logic [NUM_INPUTS-1:0] select_status,
    // Preset load port towards the mixer
    output var  logic                  load_valid,
    output var  rpam_idx_t             load_preset,
    output var  logic [31:0]           load_params,
    // Preset state
    output var  logic [NUM_PRESETS-1:0] preset_state,
    output var  logic [NUM_PRESETS-1:0] preset_enabled
);

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------
    function automatic rpam_dec_s decode(input logic [31:0] a);
        rpam_dec_s  d;
        logic [5:0] w;
        d.kind = K_NONE;
        d.idx  = '0;
        w      = a[7:2];
        if (a[31:8] == ADDR_HIGH_ZERO && a[1:0] == 2'h0) begin
            if (w == IDX_CMD) begin
                d.kind = K_CMD;
            end else if (w == IDX_STATUS) begin
                d.kind = K_STATUS;
            end else if (w == IDX_INPUTS) begin
                d.kind = K_INPUTS;
            end else if (w >= IDX_MASK0 && w < IDX_MASK_END) begin
                d.kind = K_MASK;
                d.idx  = rpam_idx_t'(w - IDX_MASK0);
            end else if (w >= IDX_PARAM0 && w < IDX_PARAM_END) begin
                d.kind = K_PARAM;
                d.idx  = rpam_idx_t'(w - IDX_PARAM0);
            end
        end
        return d;
    endfunction

    function automatic logic mask_match(input rpam_mask_s m, input logic [NUM_INPUTS-1:0] lv);
        return (|m.used) && ((m.used & (lv ^ m.level)) == '0);
    endfunction

    // ----------------------------------------------------------------
    // Contact input synchroniser and latch
    // ----------------------------------------------------------------
    logic [NUM_INPUTS-1:0] sync1_ff, sync2_ff, select_status_ff;
    logic [NUM_INPUTS-1:0] nxt_sync1, nxt_sync2, nxt_select_status;

    always_comb begin
        nxt_sync1         = select_in;
        nxt_sync2         = sync1_ff;
        nxt_select_status = sync2_ff;                    // [RULE14]
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff         <= '0;
            sync2_ff         <= '0;
            select_status_ff <= '0;
        end else begin
            sync1_ff         <= nxt_sync1;
            sync2_ff         <= nxt_sync2;
            select_status_ff <= nxt_select_status;
        end
    end

    assign select_status = select_status_ff;

    // ----------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY
    // ----------------------------------------------------------------
    rpam_aph_s   aph_ff, nxt_aph;
    logic [31:0] hrdata_ff, nxt_hrdata;
    logic        hreadyout_ff, hresp_ff;
    rpam_dec_s   rd_dec, wr_dec;
    logic        rd_take;

    rpam_parse_e parse_ff;
    logic        num_ok_ff;
    rpam_cmd_s   cmd_ff;
    rpam_mask_s  mask_ff [NUM_PRESETS];
    logic [31:0] params_ff [NUM_PRESETS];
    logic [NUM_PRESETS-1:0] state_ff, pend_ff, pend_on_ff, en_ff;

    always_comb begin
        rd_dec      = decode(haddr);
        wr_dec      = decode(aph_ff.addr);
        rd_take     = hsel && htrans[1] && hready && !hwrite;
        nxt_aph.wr  = hsel && htrans[1] && hready && hwrite && (hsize == HSIZE_WORD);
        nxt_aph.addr = haddr;
        nxt_hrdata  = '0;
        if (rd_take) begin
            unique case (rd_dec.kind)
                K_CMD:    nxt_hrdata = 32'(parse_ff);
                K_STATUS: begin
                    nxt_hrdata[STAT_STATE_LSB +: NUM_PRESETS] = state_ff;
                    nxt_hrdata[STAT_EN_LSB +: NUM_PRESETS]    = en_ff;
                    nxt_hrdata[STAT_PEND_LSB +: NUM_PRESETS]  = pend_ff;
                end
                K_INPUTS: nxt_hrdata[NUM_INPUTS-1:0] = sync2_ff;
                K_MASK: begin
                    nxt_hrdata[MASK_LVL_LSB +: NUM_INPUTS] = mask_ff[rd_dec.idx].level;
                    nxt_hrdata[MASK_USE_LSB +: NUM_INPUTS] = mask_ff[rd_dec.idx].used;
                end
                K_PARAM:  nxt_hrdata = params_ff[rd_dec.idx];
                K_NONE:   nxt_hrdata = '0;
                default:  nxt_hrdata = '0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aph_ff       <= '0;
            hrdata_ff    <= '0;
            hreadyout_ff <= 1'b1;
            hresp_ff     <= HRESP_OKAY;
        end else begin
            aph_ff       <= nxt_aph;
            hrdata_ff    <= nxt_hrdata;
            hreadyout_ff <= 1'b1;
            hresp_ff     <= HRESP_OKAY;
        end
    end

    assign hrdata    = hrdata_ff;
    assign hreadyout = hreadyout_ff;
    assign hresp     = hresp_ff;

    // ----------------------------------------------------------------
    // Command parser: one token byte per write to the command register
    // ----------------------------------------------------------------
    rpam_parse_e nxt_parse;
    logic        nxt_num_ok;
    rpam_cmd_s   nxt_cmd, num_ff, nxt_num;
    logic [7:0]  tok;
    logic        tok_wr;

    always_comb begin
        tok        = hwdata[7:0];
        tok_wr     = aph_ff.wr && (wr_dec.kind == K_CMD);
        nxt_parse  = parse_ff;
        nxt_num_ok = num_ok_ff;
        nxt_num    = num_ff;
        nxt_cmd    = '0;
        if (tok_wr) begin
            unique case (parse_ff)                       // [RULE8]
                PS_TOKEN: nxt_parse = (tok == TOK_EXEC) ? PS_KEY : PS_TOKEN;
                PS_KEY:   nxt_parse = (tok == TOK_PRESET) ? PS_NUM : PS_TOKEN;
                PS_NUM: begin
                    nxt_num.num = rpam_idx_t'(tok);
                    nxt_num_ok  = (tok >= PRESET_MIN) && (tok <= PRESET_MAX);
                    nxt_parse   = PS_ARG;
                end
                PS_ARG: begin
                    nxt_cmd.valid = num_ok_ff && (tok <= ARG_MAX);   // [RULE16]
                    nxt_cmd.num   = num_ff.num;
                    nxt_cmd.arg   = tok[1:0];
                    nxt_parse     = PS_TOKEN;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            parse_ff  <= PS_TOKEN;
            num_ok_ff <= 1'b0;
            num_ff    <= '0;
            cmd_ff    <= '0;
        end else begin
            parse_ff  <= nxt_parse;
            num_ok_ff <= nxt_num_ok;
            num_ff    <= nxt_num;
            cmd_ff    <= nxt_cmd;
        end
    end

    // ----------------------------------------------------------------
    // Presets: masks, parameters, state and load sequencing
    // ----------------------------------------------------------------
    rpam_mask_s  nxt_mask [NUM_PRESETS];
    logic [31:0] nxt_params [NUM_PRESETS];
    logic [NUM_PRESETS-1:0] nxt_state, nxt_pend, nxt_pend_on, nxt_en;
    logic [NUM_PRESETS-1:0] rise_w, fall_w, hit_w, act_on, act_off, act_run_off;
    logic        load_valid_ff, nxt_load_valid, issued;
    rpam_idx_t   load_preset_ff, nxt_load_preset;
    logic [31:0] load_params_ff, nxt_load_params;

    always_comb begin
        nxt_state       = state_ff;
        nxt_pend        = pend_ff;
        nxt_pend_on     = pend_on_ff;
        nxt_load_valid  = 1'b0;
        nxt_load_preset = load_preset_ff;
        nxt_load_params = load_params_ff;
        issued          = 1'b0;
        for (int p = 0; p < NUM_PRESETS; p++) begin
            nxt_mask[p]   = mask_ff[p];
            nxt_params[p] = params_ff[p];
            nxt_en[p]     = mask_match(mask_ff[p], sync2_ff);          // [RULE5] [RULE6] [RULE15]
            rise_w[p]     = nxt_en[p] && !en_ff[p];                    // [RULE4]
            fall_w[p]     = !nxt_en[p] && en_ff[p];
            hit_w[p]      = cmd_ff.valid && (cmd_ff.num == rpam_idx_t'(p + 1));  // [RULE7]
            act_on[p]     = hit_w[p] ? (cmd_ff.arg == ARG_RUN_ON)  : rise_w[p];
            act_off[p]    = hit_w[p] ? (cmd_ff.arg == ARG_OFF)     : fall_w[p];
            act_run_off[p] = hit_w[p] && (cmd_ff.arg == ARG_RUN_OFF);
            if (aph_ff.wr && wr_dec.idx == rpam_idx_t'(p)) begin       // [RULE2] [RULE3]
                if (wr_dec.kind == K_MASK) begin
                    nxt_mask[p].level = hwdata[MASK_LVL_LSB +: NUM_INPUTS];
                    nxt_mask[p].used  = hwdata[MASK_USE_LSB +: NUM_INPUTS];
                end
                if (wr_dec.kind == K_PARAM) begin
                    nxt_params[p] = hwdata;
                end
            end
        end
        // Lowest pending preset is put out first, one load per cycle
        for (int p = 0; p < NUM_PRESETS; p++) begin
            if (pend_ff[p] && !issued) begin
                issued          = 1'b1;
                nxt_load_valid  = 1'b1;                                // [RULE1]
                nxt_load_preset = rpam_idx_t'(p + 1);
                nxt_load_params = params_ff[p];
                nxt_pend[p]     = 1'b0;
                nxt_pend_on[p]  = 1'b0;
                if (pend_on_ff[p]) begin
                    nxt_state[p] = 1'b1;                               // [RULE13]
                end
            end
        end
        for (int p = 0; p < NUM_PRESETS; p++) begin
            if (act_off[p]) begin                                      // [RULE9]
                nxt_state[p]   = 1'b0;
                nxt_pend[p]    = 1'b0;
                nxt_pend_on[p] = 1'b0;
            end else if (act_on[p] && !state_ff[p] && !(pend_ff[p] && pend_on_ff[p])) begin
                nxt_pend[p]    = 1'b1;                                 // [RULE10] [RULE12]
                nxt_pend_on[p] = 1'b1;
            end else if (act_run_off[p]) begin                         // [RULE11]
                nxt_state[p]   = 1'b0;
                nxt_pend[p]    = 1'b1;
                nxt_pend_on[p] = 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_ff       <= '0;
            pend_ff        <= '0;
            pend_on_ff     <= '0;
            en_ff          <= '0;
            load_valid_ff  <= 1'b0;
            load_preset_ff <= '0;
            load_params_ff <= '0;
            for (int p = 0; p < NUM_PRESETS; p++) begin
                mask_ff[p]   <= MASK_RST;
                params_ff[p] <= PARAM_RST;
            end
        end else begin
            state_ff       <= nxt_state;
            pend_ff        <= nxt_pend;
            pend_on_ff     <= nxt_pend_on;
            en_ff          <= nxt_en;
            load_valid_ff  <= nxt_load_valid;
            load_preset_ff <= nxt_load_preset;
            load_params_ff <= nxt_load_params;
            for (int p = 0; p < NUM_PRESETS; p++) begin
                mask_ff[p]   <= nxt_mask[p];
                params_ff[p] <= nxt_params[p];
            end
        end
    end

    assign load_valid     = load_valid_ff;
    assign load_preset    = load_preset_ff;
    assign load_params    = load_params_ff;
    assign preset_state   = state_ff;
    assign preset_enabled = en_ff;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_parse_order: assert property (cmd_ff.valid |-> $past(parse_ff) == PS_ARG) // [RULE8]
        else $error("command issued outside the argument step");

    a_bad_cmd_ignored: assert property ( // [RULE16]
        (tok_wr && parse_ff == PS_ARG && (!num_ok_ff || tok > ARG_MAX)) |=> !cmd_ff.valid)
        else $error("invalid command was not ignored");

    a_latched_status: assert property ( // [RULE14]
        $stable(select_in)[*4] |-> select_status == select_in)
        else $error("contact status does not follow latched input");

    for (genvar g = 0; g < NUM_PRESETS; g++) begin : g_chk
        a_load_before_on: assert property ( // [RULE13]
            $rose(state_ff[g]) |-> load_valid_ff && load_preset_ff == rpam_idx_t'(g + 1))
            else $error("preset marked on without a load");

        a_arg0_off: assert property ( // [RULE9]
            (hit_w[g] && cmd_ff.arg == ARG_OFF) |=> !state_ff[g] && !pend_ff[g] ##1 !load_valid_ff
                || load_preset_ff != rpam_idx_t'(g + 1))
            else $error("argument 0 did not turn the preset off");

        a_arg1_load: assert property ( // [RULE10]
            (hit_w[g] && cmd_ff.arg == ARG_RUN_ON && !state_ff[g] && !pend_ff[g])
                |=> pend_ff[g] && pend_on_ff[g])
            else $error("argument 1 did not queue a load");

        a_arg2_stays_off: assert property ( // [RULE11]
            (hit_w[g] && cmd_ff.arg == ARG_RUN_OFF)
                |=> pend_ff[g] && !pend_on_ff[g] && !state_ff[g])
            else $error("argument 2 did not load with state off");

        a_on_no_reload: assert property ( // [RULE12]
            (hit_w[g] && cmd_ff.arg == ARG_RUN_ON && state_ff[g] && !pend_ff[g]) |=> !pend_ff[g])
            else $error("preset already on was reloaded");

        a_mask_mismatch: assert property ( // [RULE15]
            (|(mask_ff[g].used & (sync2_ff ^ mask_ff[g].level))) |=> !en_ff[g])
            else $error("preset enabled despite a contact mismatch");

        a_other_untouched: assert property ( // [RULE2]
            (!hit_w[g] && !rise_w[g] && !fall_w[g] && !pend_ff[g]) |=> $stable(state_ff[g]))
            else $error("preset state changed without its own cause");
    end

    c_load_issued: cover property (load_valid_ff ##1 load_valid_ff);
    c_two_rooms_on: cover property ($countones(state_ff) >= 2);
    c_contact_run: cover property (|rise_w ##[1:4] $rose(|state_ff));
    c_run_off: cover property (cmd_ff.valid && cmd_ff.arg == ARG_RUN_OFF);

endmodule

`default_nettype wire

/* File: verif/rpam_switches.sv */
// Partition contact switches model driving the preset control inputs
`default_nettype none
module rpam_switches import rpam_pkg::*; (
    // Clock
    input  wire logic                  clock,
    // Wanted partition positions, 1 = closed
    input  wire logic [NUM_INPUTS-1:0] closed,
    // Contact levels towards the block
    output var  logic [NUM_INPUTS-1:0] select_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Latching contacts
    // ----------------------------------------------------------------
    initial select_in = '0;
    // A switch keeps its level until the partition is moved
    always @(posedge clock) select_in <= closed;
endmodule
`default_nettype wire

/* File: verif/room_preset_activation_manager_tb_top.sv */
// Self-checking testbench of the room preset activation manager
`default_nettype none
module room_preset_activation_manager_tb_top import rpam_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic                   clock, rst_n, hsel, hwrite, hreadyout, hresp, load_valid;
    logic [1:0]             htrans;
    logic [2:0]             hsize;
    logic [31:0]            haddr, hwdata, hrdata, load_params, rd;
    logic [NUM_INPUTS-1:0]  closed, select_in, select_status, sel;
    rpam_idx_t              load_preset;
    logic [NUM_PRESETS-1:0] preset_state, preset_enabled, st, en;
    logic [31:0]            par [NUM_PRESETS];
    logic [15:0]            msk [NUM_PRESETS] = '{16'h0101, 16'h0303, 16'h0202,
                                                  16'h0301, 16'h0302, 16'h0300};
    logic [34:0]            want [$];
    logic [34:0]            got [$];
    logic [15:0]            lfsr_q;
    int                     n_fail, comparisons;
    logic                   e;

    always #4 clock = ~clock;

    rpam_top dut (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .select_in(select_in),
        .select_status(select_status), .load_valid(load_valid), .load_preset(load_preset),
        .load_params(load_params), .preset_state(preset_state),
        .preset_enabled(preset_enabled));
    rpam_switches sw (.clock(clock), .closed(closed), .select_in(select_in));

    always @(negedge clock) if (load_valid === 1'b1) got.push_back({load_preset, load_params});

    // ----------------------------------------------------------------
    // Bus, model and compare helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string what, input logic [34:0] exp, input logic [34:0] seen);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rdchk(input string what, input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(what, {3'h0, exp}, {3'h0, rd});
    endtask

    task automatic apply(input int n, input int a);
        if (n >= 1 && n <= 6 && a >= 0 && a <= 2) begin
            if (a == 0) st[n-1] = 1'b0;
            else if (!(a == 1 && st[n-1])) begin
                want.push_back({3'(n), par[n-1]});
                st[n-1] = (a == 1);
            end
        end
    endtask

    task automatic check_all();
        repeat (14) @(posedge clock);
        chk("state", {29'h0, st}, {29'h0, preset_state});
        chk("enabled", {29'h0, en}, {29'h0, preset_enabled});
        chk("contact status", {28'h0, sel}, {28'h0, select_status});
        chk("load count", 35'(want.size()), 35'(got.size()));
        while (want.size() > 0 && got.size() > 0) begin
            chk("load", want.pop_front(), got.pop_front());
        end
        want.delete();
        got.delete();
        rdchk("status reg", 32'h4, {16'h0, 2'h0, en, 2'h0, st});
        rdchk("inputs reg", 32'h8, {25'h0, sel});
    endtask

    task automatic cmd(input int n, input int a);
        bus(1'b1, 32'h0, 32'h40);
        bus(1'b1, 32'h0, 32'h50);
        bus(1'b1, 32'h0, 32'(n));
        bus(1'b1, 32'h0, 32'(a));
        apply(n, a);
        check_all();
    endtask

    task automatic contacts(input logic [NUM_INPUTS-1:0] c);
        closed <= c;
        sel = c;
        for (int p = 0; p < NUM_PRESETS; p++) begin
            e = (msk[p][14:8] != 7'h0) && (((c ^ msk[p][6:0]) & msk[p][14:8]) == 7'h0);
            if (e != en[p]) apply(p + 1, e ? 1 : 0);
            en[p] = e;
        end
        check_all();
    endtask

    task automatic results();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        results();
    end

    initial begin
        {clock, rst_n, hsel, hwrite, htrans, haddr, hwdata, closed, sel, st, en} = '0;
        hsize = HSIZE_WORD;
        n_fail = 0;
        comparisons = 0;
        lfsr_q = 16'h0044;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk("hreadyout", 35'h1, {34'h0, hreadyout});
        chk("hresp", 35'h0, {34'h0, hresp});
        for (int p = 0; p < NUM_PRESETS; p++) begin
            lfsr_q = lfsr(lfsr_q);
            par[p] = {lfsr_q, ~lfsr_q};
            bus(1'b1, 32'h30 + 32'(4 * p), par[p]);
        end
        hsize <= 3'h0;
        bus(1'b1, 32'h30, 32'h0);
        hsize <= HSIZE_WORD;
        @(posedge clock);
        for (int p = 0; p < NUM_PRESETS; p++) begin
            rdchk("param", 32'h30 + 32'(4 * p), par[p]);
        end
        rdchk("unmapped", 32'h48, 32'h0);
        rdchk("high address", 32'h130, 32'h0);
        bus(1'b1, 32'h0, 32'h40);
        rdchk("parser step", 32'h0, 32'h1);
        bus(1'b1, 32'h0, 32'h41);
        rdchk("parser step", 32'h0, 32'h0);
        cmd(2, 1);
        cmd(2, 1);
        cmd(3, 2);
        cmd(3, 1);
        cmd(2, 0);
        cmd(7, 1);
        cmd(0, 1);
        cmd(4, 3);
        foreach (par[p]) for (int a = 2; a >= 0; a--) cmd(p + 1, (a + 2) % 3);
        for (int p = 0; p < NUM_PRESETS; p++) bus(1'b1, 32'h10 + 32'(4 * p), {16'h0, msk[p]});
        for (int p = 0; p < NUM_PRESETS; p++) begin
            rdchk("mask", 32'h10 + 32'(4 * p), {16'h0, msk[p]});
        end
        contacts(sel);
        repeat (12) begin
            lfsr_q = lfsr(lfsr_q);
            contacts(lfsr_q[NUM_INPUTS-1:0]);
        end
        cmd(1, 1);
        results();
    end
endmodule
`default_nettype wire
